// ==== common/sfcrf_defines.svh ====
// Constants of the serial flash command and read front end
`ifndef SFCRF_DEFINES_SVH
`define SFCRF_DEFINES_SVH

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define SFCRF_OP_READ 8'h03
`define SFCRF_OP_FAST 8'h0B
`define SFCRF_OP_DISC 8'h5A
`define SFCRF_OP_DUAL 8'hBB
`define SFCRF_OP_WQUAD 8'hE7
`define SFCRF_OP_QIO 8'hEB
`define SFCRF_OP_STAT_RD 8'h05
`define SFCRF_OP_LATCH_SET 8'h06
`define SFCRF_OP_LATCH_CLR 8'h04
`define SFCRF_OP_QUAD_ENTER 8'h35
`define SFCRF_OP_QUAD_EXIT 8'hF5

// ------------------------------------------------------------
// Phase lengths (dummy in clocks, others in bits)
// ------------------------------------------------------------
`define SFCRF_DUMMY_NONE 4'h0
`define SFCRF_DUMMY_FAST 4'h8
`define SFCRF_DUMMY_DUAL 4'h4
`define SFCRF_DUMMY_WQUAD 4'h4
`define SFCRF_DUMMY_QPI_FAST 4'h4
`define SFCRF_DUMMY_QIO 4'h6
`define SFCRF_CMD_BITS 5'h08
`define SFCRF_ADDR_BITS 5'h18

// ------------------------------------------------------------
// Lane widths
// ------------------------------------------------------------
`define SFCRF_W_NONE 3'h0
`define SFCRF_W_SINGLE 3'h1
`define SFCRF_W_DUAL 3'h2
`define SFCRF_W_QUAD 3'h4

// ------------------------------------------------------------
// Status byte, reset values, buffering
// ------------------------------------------------------------
`define SFCRF_STAT_BUSY_BIT 0
`define SFCRF_STAT_WEL_BIT 1
`define SFCRF_WEL_RST 1'b0
`define SFCRF_QUAD_RST 1'b0
`define SFCRF_FILL_BYTE 8'hFF
`define SFCRF_FIFO_WIDTH 8
`define SFCRF_FIFO_DEPTH 8

`endif

// ==== common/sfcrf_pkg.sv ====
// Types shared by the serial flash front end
`default_nettype none
`include "sfcrf_defines.svh"
package sfcrf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_HOLD,
    ST_STANDBY
  } sfcrf_state_type;

  // Shape of one decoded instruction
  typedef struct packed {
    logic ok;
    logic arr;
    logic [2:0] addr_w;
    logic [3:0] dummy;
    logic [2:0] data_w;
  } sfcrf_prof_type;

  // Pin bundle as seen after synchronisation
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic [3:0] io;
  } sfcrf_pins_type;

endpackage
`default_nettype wire

// ==== hdl/sfcrf_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a flush
`default_nettype none
module sfcrf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (flush) begin
      cnt_d = '0;
    end else if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      // Registered ready: full is known one cycle ahead from the next count
      in_ready <= (cnt_d != (AW + 1)'(DEPTH));
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
      end else begin
        if (push) begin
          wr_q <= (wr_q == (AW)'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= (rd_q == (AW)'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/sfcrf_front.sv ====
// Serial flash command decode and read front end
`default_nettype none
`include "sfcrf_defines.svh"
module sfcrf_front (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Flash pins
  input wire logic CS_B,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  // Array data stream
  output logic [23:0] ARR_ADDR,
  output logic ARR_RD_EN,
  input wire logic ARR_VALID,
  input wire logic [7:0] ARR_DATA,
  output logic ARR_READY,
  // Core status and mode
  input wire logic BUSY,
  input wire logic [5:0] STAT_HI,
  output logic WRITE_ENABLE_LATCH,
  output logic QUAD_MODE
);
  import sfcrf_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] io,
                                           input logic [2:0] w);
    unique case (w)
      `SFCRF_W_SINGLE: return {s[22:0], io[0]};
      `SFCRF_W_DUAL: return {s[21:0], io[1:0]};
      default: return {s[19:0], io};
    endcase
  endfunction

  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] w);
    unique case (w)
      `SFCRF_W_SINGLE: return {2'h0, b[7], 1'h0};
      `SFCRF_W_DUAL: return {2'h0, b[7:6]};
      default: return b[7:4];
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] w);
    unique case (w)
      `SFCRF_W_SINGLE: return 4'h2;
      `SFCRF_W_DUAL: return 4'h3;
      default: return 4'hF;
    endcase
  endfunction

  function automatic sfcrf_prof_type decode(input logic [7:0] op, input logic quad,
                                            input logic busy);
    sfcrf_prof_type p;
    p = '0;
    p.ok = 1'b1;
    if (quad) begin
      // Every phase on four lines in quad command mode
      case (op)
        `SFCRF_OP_FAST: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_QUAD;
          p.dummy = `SFCRF_DUMMY_QPI_FAST;
          p.data_w = `SFCRF_W_QUAD;
        end
        `SFCRF_OP_QIO: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_QUAD;
          p.dummy = `SFCRF_DUMMY_QIO;
          p.data_w = `SFCRF_W_QUAD;
        end
        `SFCRF_OP_STAT_RD: p.data_w = `SFCRF_W_QUAD;
        `SFCRF_OP_LATCH_SET, `SFCRF_OP_LATCH_CLR,
        `SFCRF_OP_QUAD_ENTER, `SFCRF_OP_QUAD_EXIT: p.data_w = `SFCRF_W_NONE;
        default: p.ok = 1'b0;
      endcase
    end else begin
      case (op)
        `SFCRF_OP_READ: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_SINGLE;
          p.dummy = `SFCRF_DUMMY_NONE;
          p.data_w = `SFCRF_W_SINGLE;
        end
        `SFCRF_OP_FAST, `SFCRF_OP_DISC: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_SINGLE;
          p.dummy = `SFCRF_DUMMY_FAST;
          p.data_w = `SFCRF_W_SINGLE;
        end
        `SFCRF_OP_DUAL: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_DUAL;
          p.dummy = `SFCRF_DUMMY_DUAL;
          p.data_w = `SFCRF_W_DUAL;
        end
        `SFCRF_OP_WQUAD: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_QUAD;
          p.dummy = `SFCRF_DUMMY_WQUAD;
          p.data_w = `SFCRF_W_QUAD;
        end
        `SFCRF_OP_QIO: begin
          p.arr = 1'b1;
          p.addr_w = `SFCRF_W_QUAD;
          p.dummy = `SFCRF_DUMMY_QIO;
          p.data_w = `SFCRF_W_QUAD;
        end
        `SFCRF_OP_STAT_RD: p.data_w = `SFCRF_W_SINGLE;
        `SFCRF_OP_LATCH_SET, `SFCRF_OP_LATCH_CLR,
        `SFCRF_OP_QUAD_ENTER, `SFCRF_OP_QUAD_EXIT: p.data_w = `SFCRF_W_NONE;
        default: p.ok = 1'b0;
      endcase
    end
    // Array access during a write cycle is refused, the core is untouched
    if (p.arr && busy) begin
      p.ok = 1'b0;
    end
    return p;
  endfunction

  // ------------------------------------------------------------
  // Pin sampling and clock edges
  // ------------------------------------------------------------
  sfcrf_pins_type pins_raw;
  sfcrf_pins_type pins_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic rise;
  logic fall;
  logic cs_rise;

  assign pins_raw = '{cs_b: CS_B, sclk: SCLK, io: IO_IN};

  sfcrf_sync #(
    .WIDTH($bits(sfcrf_pins_type)),
    .RST_VAL(6'h20)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d(pins_raw),
    .q(pins_s)
  );

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= pins_s.sclk;
      cs_prev_q <= pins_s.cs_b;
    end
  end

  // Either idle level works: only edges inside the frame are used
  assign rise = !pins_s.cs_b && pins_s.sclk && !sclk_prev_q;
  assign fall = !pins_s.cs_b && !pins_s.sclk && sclk_prev_q;
  assign cs_rise = pins_s.cs_b && !cs_prev_q;

  // ------------------------------------------------------------
  // Frame sequencing
  // ------------------------------------------------------------
  sfcrf_state_type st_q;
  sfcrf_prof_type prof_q;
  sfcrf_prof_type prof_d;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [2:0] cmd_w;
  logic [7:0] op_q;
  logic extra_q;
  logic quad_q;
  logic wel_q;

  assign cmd_w = quad_q ? `SFCRF_W_QUAD : `SFCRF_W_SINGLE;
  assign sh_d = shift_in(sh_q, pins_s.io, (st_q == ST_ADDR) ? prof_q.addr_w : cmd_w);
  assign cnt_d = cnt_q + 5'((st_q == ST_ADDR) ? prof_q.addr_w : cmd_w);
  assign prof_d = decode(sh_d[7:0], quad_q, BUSY);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q <= ST_IDLE;
      prof_q <= '0;
      sh_q <= '0;
      cnt_q <= '0;
      op_q <= '0;
      extra_q <= 1'b0;
    end else if (pins_s.cs_b) begin
      // Chip select high ends active mode and standby alike
      st_q <= ST_IDLE;
      cnt_q <= '0;
      extra_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_q <= ST_CMD;
          cnt_q <= '0;
        end
        ST_CMD: if (rise) begin
          sh_q <= sh_d;
          cnt_q <= cnt_d;
          if (cnt_d == `SFCRF_CMD_BITS) begin
            op_q <= sh_d[7:0];
            prof_q <= prof_d;
            cnt_q <= '0;
            if (!prof_d.ok) begin
              st_q <= ST_STANDBY;
            end else if (prof_d.addr_w != `SFCRF_W_NONE) begin
              st_q <= ST_ADDR;
            end else if (prof_d.data_w != `SFCRF_W_NONE) begin
              st_q <= ST_DATA;
            end else begin
              st_q <= ST_HOLD;
            end
          end
        end
        ST_ADDR: if (rise) begin
          sh_q <= sh_d;
          cnt_q <= cnt_d;
          if (cnt_d == `SFCRF_ADDR_BITS) begin
            cnt_q <= '0;
            st_q <= (prof_q.dummy == `SFCRF_DUMMY_NONE) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: if (rise) begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q + 5'h01 == {1'b0, prof_q.dummy}) begin
            st_q <= ST_DATA;
          end
        end
        // Any clock after the opcode breaks the byte boundary
        ST_HOLD: if (rise) begin
          extra_q <= 1'b1;
        end
        ST_DATA, ST_STANDBY: st_q <= st_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Mode and write latch, acted on at chip select release
  // ------------------------------------------------------------
  logic exec;

  assign exec = cs_rise && (st_q == ST_HOLD) && !extra_q;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      quad_q <= `SFCRF_QUAD_RST;
      wel_q <= `SFCRF_WEL_RST;
    end else if (exec) begin
      unique case (op_q)
        `SFCRF_OP_QUAD_ENTER: quad_q <= 1'b1;
        `SFCRF_OP_QUAD_EXIT: quad_q <= 1'b0;
        `SFCRF_OP_LATCH_SET: wel_q <= 1'b1;
        `SFCRF_OP_LATCH_CLR: wel_q <= 1'b0;
        default: wel_q <= wel_q;
      endcase
    end
  end

  assign WRITE_ENABLE_LATCH = wel_q;
  assign QUAD_MODE = quad_q;

  // ------------------------------------------------------------
  // Array fetch into the buffer
  // ------------------------------------------------------------
  logic rd_en_q;
  logic [23:0] addr_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rd_en_q <= 1'b0;
      addr_q <= '0;
    end else begin
      rd_en_q <= !pins_s.cs_b && (st_q == ST_DATA) && prof_q.arr;
      if (!rd_en_q) begin
        addr_q <= sh_q;
      end else if (ARR_VALID && fifo_in_ready) begin
        addr_q <= addr_q + 24'h000001;
      end
    end
  end

  // Flush while idle so no stale byte leaks into the next frame
  sfcrf_fifo #(
    .WIDTH(`SFCRF_FIFO_WIDTH),
    .DEPTH(`SFCRF_FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .flush(!rd_en_q),
    .in_valid(ARR_VALID && rd_en_q),
    .in_data(ARR_DATA),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  assign ARR_ADDR = addr_q;
  assign ARR_RD_EN = rd_en_q;
  assign ARR_READY = fifo_in_ready;

  // ------------------------------------------------------------
  // Output shifter
  // ------------------------------------------------------------
  logic [7:0] out_q;
  logic [3:0] left_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;
  logic [7:0] stat_byte;
  logic [7:0] next_byte;
  logic load;

  always_comb begin
    stat_byte = {STAT_HI, 2'h0};
    stat_byte[`SFCRF_STAT_WEL_BIT] = wel_q;
    stat_byte[`SFCRF_STAT_BUSY_BIT] = BUSY;
  end

  assign load = fall && (st_q == ST_DATA) && (left_q == 4'h0);
  assign fifo_pop = load && prof_q.arr;
  // An empty buffer sends fill bytes rather than stalling the host clock
  assign next_byte = !prof_q.arr ? stat_byte : (fifo_out_valid ? fifo_out_data : `SFCRF_FILL_BYTE);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      out_q <= '0;
      left_q <= '0;
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (pins_s.cs_b || st_q != ST_DATA) begin
      // Lines stay released outside the data phase and in standby
      left_q <= '0;
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (fall) begin
      io_oe_q <= lane_mask(prof_q.data_w);
      if (load) begin
        io_out_q <= lane_bits(next_byte, prof_q.data_w);
        out_q <= next_byte << prof_q.data_w;
        left_q <= 4'h8 - {1'b0, prof_q.data_w};
      end else begin
        io_out_q <= lane_bits(out_q, prof_q.data_w);
        out_q <= out_q << prof_q.data_w;
        left_q <= left_q - {1'b0, prof_q.data_w};
      end
    end
  end

  assign IO_OUT = io_out_q;
  assign IO_OE = io_oe_q;

endmodule
`default_nettype wire

// ==== hdl/sfcrf_sync.sv ====
// Two-flop synchroniser for a bundle of pin levels
`default_nettype none
module sfcrf_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/unused_placeholder_none.sv ====
// Empty compilation unit kept out of the build
`default_nettype none
`default_nettype wire

// ==== test/sfcrf_front_checker.sv ====
// Concurrent checks on the ports of the serial flash front end
`default_nettype none
module sfcrf_front_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Flash pins
  input wire logic CS_B,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE,
  // Array data stream
  input wire logic [23:0] ARR_ADDR,
  input wire logic ARR_RD_EN,
  input wire logic ARR_VALID,
  input wire logic [7:0] ARR_DATA,
  input wire logic ARR_READY,
  // Core status and mode
  input wire logic BUSY,
  input wire logic [5:0] STAT_HI,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic QUAD_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Six deselected clocks leave room for the pin synchronisers
  chk_oe_released: assert property (CS_B [*6] |-> IO_OE == 4'h0)
    else $error("output enables still on after deselect");
  chk_rden_end: assert property (CS_B [*6] |-> !ARR_RD_EN)
    else $error("array stream still active after deselect");
  chk_lane_set: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("output enables form no lane set");
  chk_quad_lanes: assert property (QUAD_MODE && IO_OE != 4'h0 |-> IO_OE == 4'hF)
    else $error("quad command mode data not on four lines");
  chk_out_steady: assert property ((!CS_B && SCLK) [*6] |-> $stable(IO_OUT) && $stable(IO_OE))
    else $error("outputs moved while the link clock stood high");
  chk_busy_block: assert property (BUSY [*4] |-> !$rose(ARR_RD_EN))
    else $error("array stream started while busy");
  chk_addr_step: assert property (ARR_RD_EN && ARR_VALID && ARR_READY |=>
      ARR_ADDR == $past(ARR_ADDR) + 24'h000001)
    else $error("address did not step after an accepted byte");
  chk_addr_hold: assert property (ARR_RD_EN && $past(ARR_RD_EN && !(ARR_VALID && ARR_READY))
      |-> $stable(ARR_ADDR))
    else $error("address moved without an accepted byte");
  chk_ready_cause: assert property ($fell(ARR_READY) |-> $past(ARR_RD_EN && ARR_VALID))
    else $error("buffer became full without a write");
  chk_latch_at_end: assert property ($changed(WRITE_ENABLE_LATCH) |-> $past(CS_B, 2))
    else $error("write latch changed inside a frame");
  chk_quad_at_end: assert property ($changed(QUAD_MODE) |-> $past(CS_B, 2))
    else $error("command mode changed inside a frame");
endmodule

bind sfcrf_front sfcrf_front_checker sfcrf_front_checker_i (
  .CLK(CLK), .RST_B(RST_B), .CS_B(CS_B), .SCLK(SCLK), .IO_IN(IO_IN), .IO_OUT(IO_OUT),
  .IO_OE(IO_OE), .ARR_ADDR(ARR_ADDR), .ARR_RD_EN(ARR_RD_EN), .ARR_VALID(ARR_VALID),
  .ARR_DATA(ARR_DATA), .ARR_READY(ARR_READY), .BUSY(BUSY), .STAT_HI(STAT_HI),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .QUAD_MODE(QUAD_MODE)
);
`default_nettype wire

// ==== test/sfcrf_front_tb_top.sv ====
// Self-checking testbench of the serial flash front end
`default_nettype none
module sfcrf_front_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ops [0:5] = '{8'h03, 8'h0B, 8'h5A, 8'hBB, 8'hE7, 8'hEB};
  localparam int aws [0:5] = '{1, 1, 1, 2, 4, 4};
  localparam int dms [0:5] = '{0, 8, 8, 4, 4, 6};
  localparam logic [3:0] oes [0:5] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'hF, 4'hF};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_b, sclk, arr_rd_en, arr_ready, write_enable_latch, quad_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] arr_addr;
  logic arr_valid = 1'b0;
  logic [7:0] arr_data = 8'h00;
  logic busy = 1'b0;
  logic [5:0] stat_hi = 6'h2D;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  sfcrf_front sfcrf_front_i (
    .CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out),
    .IO_OE(io_oe), .ARR_ADDR(arr_addr), .ARR_RD_EN(arr_rd_en), .ARR_VALID(arr_valid),
    .ARR_DATA(arr_data), .ARR_READY(arr_ready), .BUSY(busy), .STAT_HI(stat_hi),
    .WRITE_ENABLE_LATCH(write_enable_latch), .QUAD_MODE(quad_mode)
  );

  sfcrf_host_model sfcrf_host_model_i (
    .clk(clk), .cs_b(cs_b), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
  );

  function automatic logic [7:0] pat(input logic [23:0] a);
    return (a[7:0] ^ 8'h3C) + a[15:8];
  endfunction

  // ------
  // Array stand-in: a byte every other clock, so the buffer sees gaps
  // ------
  always @(posedge clk) begin
    arr_valid <= arr_rd_en && !(arr_valid && arr_ready);
    arr_data <= pat(arr_addr);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic t_latch();
    busy <= 1'b1;
    sfcrf_host_model_i.xfer(8'h05, 1, 24'h0, 0, 0, 1, 2, 0);
    check(sfcrf_host_model_i.rx[1], {stat_hi, 2'b01}, "status while busy");
    busy <= 1'b0;
    sfcrf_host_model_i.xfer(8'h06, 1, 24'h0, 0, 0, 1, 0, 0);
    check(write_enable_latch, 1, "latch set");
    sfcrf_host_model_i.xfer(8'h04, 1, 24'h0, 0, 1, 1, 0, 0);
    check(write_enable_latch, 1, "clear past byte end");
    sfcrf_host_model_i.xfer(8'h05, 1, 24'h0, 0, 0, 1, 2, 0);
    check(sfcrf_host_model_i.rx[1], {stat_hi, 2'b10}, "status with latch");
    check(sfcrf_host_model_i.oe_last, 4'h2, "status lane");
    sfcrf_host_model_i.xfer(8'h04, 1, 24'h0, 0, 0, 1, 0, 0);
    check(write_enable_latch, 0, "latch clear");
  endtask

  task automatic t_unknown();
    sfcrf_host_model_i.xfer(8'h77, 1, 24'h060606, 1, 0, 1, 2, 0);
    check(sfcrf_host_model_i.oe_any, 0, "drive after bad opcode");
    check(write_enable_latch, 0, "bus heeded after bad opcode");
  endtask

  task automatic t_reads();
    logic [23:0] a;
    for (int i = 0; i < 6; i++) begin
      a = {i[3:0], 20'hFFFFE};
      sfcrf_host_model_i.clock_idle_polarity = i[0];
      sfcrf_host_model_i.xfer(ops[i], 1, a, aws[i], dms[i], aws[i], 3, 0);
      check(sfcrf_host_model_i.oe_last, oes[i], "read lanes");
      for (int k = 0; k < 3; k++) begin
        check(sfcrf_host_model_i.rx[k], pat(a + 24'(k)), "read data");
      end
    end
    sfcrf_host_model_i.clock_idle_polarity = 1'b0;
  endtask

  task automatic t_busy();
    busy <= 1'b1;
    sfcrf_host_model_i.xfer(8'h03, 1, 24'h000010, 1, 0, 1, 2, 0);
    check(sfcrf_host_model_i.oe_any, 0, "read while busy");
    busy <= 1'b0;
  endtask

  task automatic t_fifo();
    fork
      sfcrf_host_model_i.xfer(8'h0B, 1, 24'hFFFFFC, 1, 8, 1, 10, 300);
      begin
        repeat (450) @(posedge clk);
        check(arr_ready, 0, "buffer full");
        check(arr_rd_en, 1, "stream held");
      end
    join
    for (int k = 0; k < 10; k++) begin
      check(sfcrf_host_model_i.rx[k], pat(24'hFFFFFC + 24'(k)), "stream data");
    end
  endtask

  task automatic t_quad();
    sfcrf_host_model_i.xfer(8'h35, 1, 24'h0, 0, 0, 1, 0, 0);
    check(quad_mode, 1, "quad entered");
    for (int i = 0; i < 2; i++) begin
      sfcrf_host_model_i.xfer(i ? 8'hEB : 8'h0B, 4, 24'h7FFFFF, 4, i ? 6 : 4, 4, 2, 0);
      check(sfcrf_host_model_i.oe_last, 4'hF, "quad lanes");
      check(sfcrf_host_model_i.rx[0], pat(24'h7FFFFF), "quad first");
      check(sfcrf_host_model_i.rx[1], pat(24'h800000), "quad next");
    end
    sfcrf_host_model_i.xfer(8'hF5, 4, 24'h0, 0, 0, 4, 0, 0);
    check(quad_mode, 0, "quad left");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_latch();
    t_unknown();
    t_reads();
    t_busy();
    t_fifo();
    t_quad();
    end_sim();
  end
endmodule
`default_nettype wire

// ==== test/sfcrf_host_model.sv ====
// Host flash controller model driving the link pins
`default_nettype none
module sfcrf_host_model (
  // Clock
  input wire logic clk,
  // Flash pins
  output var logic cs_b,
  output var logic sclk,
  output var logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_idle_polarity = 1'b0;
  logic oe_any = 1'b0;
  logic [3:0] oe_last = 4'h0;
  logic [7:0] rx [0:15];

  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    io_in = 4'h0;
  end

  // ------
  // One link clock of 8 clk, 320 ns: far below every read limit
  // ------
  task automatic cyc(input logic [3:0] v, input int w, inout logic [7:0] b);
    sclk <= 1'b0;
    io_in <= v;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    // Sampled late in the high phase, long after the launching fall
    oe_last = io_oe;
    oe_any = oe_any | (|io_oe);
    case (w)
      1: b = {b[6:0], io_out[1]};
      2: b = {b[5:0], io_out[1:0]};
      default: b = {b[3:0], io_out};
    endcase
  endtask

  task automatic xfer(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw,
                      input int dm, input int dw, input int nb, input int stall);
    logic [31:0] sh;
    logic [7:0] b;
    oe_any = 1'b0;
    sh = {op, a};
    b = 8'h00;
    sclk <= clock_idle_polarity;
    repeat (4) @(posedge clk);
    cs_b <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i += ow) begin
      cyc(sh[31:28] >> (4 - ow), 0, b);
      sh = sh << ow;
    end
    for (int i = 0; aw > 0 && i < 24; i += aw) begin
      cyc(sh[31:28] >> (4 - aw), 0, b);
      sh = sh << aw;
    end
    for (int i = 0; i < dm; i++) cyc(4'h0, 0, b);
    repeat (stall) @(posedge clk);
    // Released data lines show the inverse of the last level
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < 8; i += dw) cyc(~io_in, dw, b);
      rx[k] = b;
    end
    repeat (4) @(posedge clk);
    sclk <= clock_idle_polarity;
    repeat (4) @(posedge clk);
    // Deselect on a whole byte, or past it when extra dummy clocks are asked for
    cs_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire
